//--- dv/srf_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker for the status block
module srf_chk #(
  parameter [31:0] SUPPLY_LOSS_CY = 32'h14,
  parameter [31:0] FB_CY          = 32'h1e,
  parameter [31:0] SHORT_CY       = 32'h4,
  parameter [31:0] LONG_CY        = 32'h8,
  parameter [31:0] PULSE_LEN      = 32'h2
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic supply_ok,
  input wire logic instant_feedback_input,
  input wire logic instant_out,
  input wire logic delayed_out,
  input wire logic power_led,
  input wire logic first_channel_led,
  input wire logic second_channel_led,
  input wire logic fault_active,
  input wire logic cut_delay
);
  // Longest lit blink: timer load plus two edges of sequencing
  localparam [31:0] ON_MAX = ((SHORT_CY > (LONG_CY >> 1)) ? SHORT_CY : (LONG_CY >> 1)) + 32'h2;
  logic [31:0] lo_q, fb_q, on_q, p1_q, p2_q;
  logic        out_q;
  // Dropout, open-feedback and lit-run counters
  always_ff @(posedge sys_clk) begin
    lo_q <= supply_ok ? 32'h0 : lo_q + 32'h1;
    fb_q <= (sys_rst || instant_out || instant_feedback_input) ? 32'h0 :
            (out_q || fb_q != 32'h0) ? fb_q + 32'h1 : 32'h0;
    on_q <= (sys_rst || !fault_active || !first_channel_led) ? 32'h0 : on_q + 32'h1;
    p1_q <= (sys_rst || fault_active || !first_channel_led || instant_out) ? 32'h0 :
            p1_q + 32'h1;
    p2_q <= (sys_rst || fault_active || !second_channel_led || delayed_out) ? 32'h0 :
            p2_q + 32'h1;
    out_q <= instant_out;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_quiet: assert property ($fell(sys_rst) |-> !(instant_out || delayed_out || power_led))
    else $error("outputs not quiet after reset");
  chk_ch1_mirror: assert property (!fault_active && instant_out |-> first_channel_led)
    else $error("channel one led dark while instant output high");
  chk_ch1_pulse: assert property (p1_q <= PULSE_LEN)
    else $error("channel one led lit past a test pulse");
  chk_ch2_mirror: assert property (!fault_active && delayed_out |-> second_channel_led)
    else $error("channel two led dark while delayed output high");
  chk_ch2_pulse: assert property (p2_q <= PULSE_LEN)
    else $error("channel two led lit past a test pulse");
  chk_supply_loss: assert property (lo_q > SUPPLY_LOSS_CY + 32'h2 |-> fault_active && !instant_out && !delayed_out)
    else $error("long dropout left outputs on");
  chk_no_restart: assert property (fault_active |=> !$rose(instant_out))
    else $error("output switched on during error");
  chk_fb_timeout: assert property (fb_q > FB_CY + 32'h2 |-> fault_active)
    else $error("open feedback not flagged");
  chk_cut_delay: assert property (cut_delay |=> !delayed_out)
    else $error("delayed output kept on during delay cut");
  chk_blink_len: assert property (fault_active |-> on_q <= ON_MAX)
    else $error("fault blink lit too long");
endmodule // srf_chk
bind srf_top srf_chk #(.SUPPLY_LOSS_CY(SUPPLY_LOSS_CY), .FB_CY(FB_CY), .SHORT_CY(SHORT_CY),
  .LONG_CY(LONG_CY), .PULSE_LEN(PULSE_LEN)) i_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .supply_ok(supply_ok),
  .instant_feedback_input(instant_feedback_input), .instant_out(instant_out),
  .delayed_out(delayed_out), .power_led(power_led), .first_channel_led(first_channel_led),
  .second_channel_led(second_channel_led), .fault_active(fault_active), .cut_delay(cut_delay));
`default_nettype wire

//--- dv/srf_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Safety output of a linked unit, feeding this unit only
module srf_link_peer #(
  parameter int PER = 40
) (
  input  wire logic sys_clk,
  input  wire logic cmd_or,
  input  wire logic cmd_and,
  output var  logic or_out,
  output var  logic and_out
);
  logic [1:0] or_q  = 2'h0;
  logic [1:0] and_q = 2'h0;
  int         cnt_q = 0;
  // Own switch-on and response delay of the driving unit
  always_ff @(posedge sys_clk) begin
    or_q  <= {or_q[0], cmd_or};
    and_q <= {and_q[0], cmd_and};
    cnt_q <= (cnt_q == PER) ? 0 : cnt_q + 1;
  end
  // Brief test pulse drops a high output
  assign or_out  = or_q[1] && (cnt_q != 0);
  assign and_out = and_q[1] && (cnt_q != 0);
endmodule // srf_link_peer
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench for the status and fault indication block
module tb;
  logic        sys_clk, sys_rst, supply_ok, mode_valid, start_done, own_demand;
  logic        cmd_or, cmd_and, delay_expired, fb_inst, fb_dly, fault_req;
  logic [15:0] fault_code;
  logic [2:0]  fault_digits;
  wire         instant_out, delayed_out, power_led, ch1, ch2, fault_active, cut_delay;
  wire         or_link, and_link;
  wire         led_any = ch1 | ch2;
  int          fails = 0;
  int          total_checks = 0;
  logic [3:0]  rows [8] = '{4'h2, 4'h8, 4'h5, 4'h7, 4'hd, 4'hf, 4'h0, 4'hb}; // own,or,and,exp
  int          grp [10] = '{3, 1, 16, 3, 1, 3, 15, 3, 16, 5};
  // Shortened timing for simulation
  localparam int T_LOSS = 20, T_OFF = 40, T_FB = 30, T_INIT = 20, T_SHORT = 4;
  localparam int T_LONG = 8, T_DIGIT = 20, T_REPEAT = 30, T_PERIOD = 50, T_PLEN = 2;
  srf_top #(.SUPPLY_LOSS_CY(T_LOSS), .POWER_OFF_CY(T_OFF), .FB_CY(T_FB), .INIT_CY(T_INIT),
    .SHORT_CY(T_SHORT), .LONG_CY(T_LONG), .DIGIT_CY(T_DIGIT), .REPEAT_CY(T_REPEAT),
    .PULSE_PERIOD(T_PERIOD), .PULSE_LEN(T_PLEN)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .supply_ok(supply_ok), .mode_valid(mode_valid),
    .start_done(start_done), .own_demand(own_demand), .or_link_input(or_link),
    .and_link_input(and_link), .delay_expired(delay_expired), .instant_feedback_input(fb_inst),
    .delayed_feedback_input(fb_dly), .fault_req(fault_req), .fault_code(fault_code),
    .fault_digits(fault_digits), .instant_out(instant_out), .delayed_out(delayed_out),
    .power_led(power_led), .first_channel_led(ch1), .second_channel_led(ch2),
    .fault_active(fault_active), .cut_delay(cut_delay));
  srf_link_peer i_peer (.sys_clk(sys_clk), .cmd_or(cmd_or), .cmd_and(cmd_and),
    .or_out(or_link), .and_out(and_link));
  // Clock and watchdog
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    fails++;
    final_report;
  end
  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fails++;
      $display("mismatch at %0t: blinks %0d expected %0d", $time, got, exp);
    end
  endtask
  // Output level over ten cycles, tolerant of test pulses
  task automatic level(output logic l);
    int hi, any;
    hi = 0;
    any = 0;
    repeat (10) begin
      @(negedge sys_clk);
      hi += ((instant_out & delayed_out) === 1'h1);
      any += ((instant_out | delayed_out) !== 1'h0);
    end
    l = (hi > 5) ? 1'h1 : (any == 0) ? 1'h0 : 1'hx;
  endtask
  task automatic toggles(output int t);
    logic p;
    t = 0;
    p = power_led;
    repeat (100) begin
      @(negedge sys_clk);
      t += (power_led !== p);
      p = power_led;
    end
  endtask
  // Blinks in one group, groups split by a long dark gap
  task automatic get_group(output int n);
    int w, dk;
    w = 0;
    dk = 0;
    n = 1;
    while (led_any !== 1'h1 && w < 400) begin
      @(negedge sys_clk);
      w++;
    end
    while (dk < 14) begin
      @(negedge sys_clk);
      if (led_any !== 1'h1) dk++;
      else begin
        if (dk > 0) n++;
        dk = 0;
      end
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    int t, n;
    logic l;
    {start_done, own_demand, cmd_or, cmd_and, fault_req, mode_valid} = 6'h0;
    {delay_expired, fb_inst, fb_dly, supply_ok, sys_rst} = 5'h1f;
    fault_code = 16'h0;
    fault_digits = 3'h1;
    cyc(3);
    sys_rst = 1'h0;
    cyc(1);
    chk(instant_out | power_led | fault_active, 1'h0);
    toggles(t);
    chk(t > 1, 1'h1);
    {mode_valid, start_done} = 2'h3;
    cyc(40);
    toggles(t);
    chk(t == 0 && power_led === 1'h1, 1'h1);
    foreach (rows[i]) begin
      {own_demand, cmd_or, cmd_and} = rows[i][3:1];
      cyc(12);
      level(l);
      chk(l, rows[i][0]);
    end
    supply_ok = 1'h0;
    cyc(10);
    supply_ok = 1'h1;
    cyc(12);
    chk(fault_active, 1'h0);
    supply_ok = 1'h0;
    cyc(T_LOSS + 6);
    chk(fault_active && !(instant_out | delayed_out), 1'h1);
    supply_ok = 1'h1;
    cyc(60);
    level(l);
    chk(l, 1'h0);
    supply_ok = 1'h0;
    cyc(T_OFF - 10);
    supply_ok = 1'h1;
    cyc(60);
    chk(fault_active, 1'h1);
    supply_ok = 1'h0;
    cyc(T_OFF + 5);
    supply_ok = 1'h1;
    cyc(60);
    level(l);
    chk(l && !fault_active, 1'h1);
    {own_demand, cmd_or} = 2'h0;
    for (int c = 0; c < 2; c++) begin
      sys_rst = 1'h1;
      cyc(1);
      sys_rst = 1'h0;
      fault_code = c ? 16'hf305 : 16'h0010;
      fault_digits = c ? 3'h4 : 3'h2;
      fault_req = 1'h1;
      cyc(2);
      chk(cut_delay, 1'h1);
      for (int g = 0; g < 5; g++) begin
        get_group(n);
        chk_n(n, grp[c * 5 + g]);
      end
      fault_req = 1'h0;
    end
    // Delay release, then open feedback on instant (c=0) or delayed (c=1) side
    for (int c = 0; c < 2; c++) begin
      sys_rst = 1'h1;
      cyc(1);
      sys_rst = 1'h0;
      {own_demand, cmd_and, delay_expired} = 3'h6;
      cyc(40);
      chk(delayed_out | ch2, 1'h0);
      delay_expired = 1'h1;
      cyc(12);
      level(l);
      chk(l, 1'h1);
      {fb_inst, fb_dly} = c ? 2'h2 : 2'h1;
      own_demand = 1'h0;
      cyc(T_FB - 10);
      chk(fault_active, 1'h0);
      cyc(20);
      chk(fault_active, 1'h1);
      {fb_inst, fb_dly, own_demand} = 3'h7;
      cyc(20);
      level(l);
      chk(l, 1'h0);
    end
    final_report;
  end
endmodule // tb
`default_nettype wire

//--- rtl/srf_blink.v
`include "srf_map.vh"
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Error code blinker: preamble, digits, repeat
module srf_blink #(
  parameter [31:0] SHORT_CY  = `SRF_SHORT_CY,
  parameter [31:0] LONG_CY   = `SRF_LONG_CY,
  parameter [31:0] DIGIT_CY  = `SRF_DIGIT_GAP_CY,
  parameter [31:0] REPEAT_CY = `SRF_REPEAT_GAP_CY
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        active,
  input  wire [15:0] code,
  input  wire [2:0]  ndigits,
  output reg         led
);
  localparam [2:0] S_IDLE = 3'h0, S_PRE_ON = 3'h1, S_PRE_OFF = 3'h2, S_LONG_GAP = 3'h3;
  localparam [2:0] S_ON = 3'h4, S_OFF = 3'h5, S_DGAP = 3'h6, S_RGAP = 3'h7;
  reg  [2:0]  st_q;
  reg  [4:0]  n_q;
  reg  [1:0]  dig_q;
  reg         ld;
  reg  [31:0] ld_cnt;
  wire        done;
  wire [3:0]  dval;
  wire [4:0]  blinks;
  srf_timer u_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (ld),
    .count   (ld_cnt),
    .done    (done)
  );
  // Current digit, most significant first
  assign dval   = code[{dig_q, 2'b00} +: 4];
  assign blinks = (dval == 4'h0) ? `SRF_ZERO_BLINKS : {1'b0, dval};
  // Sequencer
  always @(posedge sys_clk) begin
    ld     <= 1'b0;
    ld_cnt <= 32'h0;
    if (sys_rst || !active) begin
      st_q <= S_IDLE;
      led  <= 1'b0;
      n_q  <= 5'h0;
      dig_q <= 2'h0;
    end else if (st_q == S_IDLE) begin
      st_q <= S_PRE_ON; led <= 1'b1; n_q <= 5'h1;
      ld <= 1'b1; ld_cnt <= SHORT_CY;
    end else if (done && !ld) begin
      case (st_q)
        S_PRE_ON: begin
          st_q <= S_PRE_OFF; led <= 1'b0; ld <= 1'b1; ld_cnt <= SHORT_CY;
        end
        S_PRE_OFF: begin
          if (n_q == {1'b0, `SRF_PREAMBLE_N}) begin
            st_q <= S_LONG_GAP; ld <= 1'b1; ld_cnt <= DIGIT_CY;
            dig_q <= ndigits[1:0] - 2'h1;
          end else begin
            n_q <= n_q + 5'h1; st_q <= S_PRE_ON; led <= 1'b1;
            ld <= 1'b1; ld_cnt <= SHORT_CY;
          end
        end
        S_LONG_GAP, S_DGAP: begin
          st_q <= S_ON; led <= 1'b1; n_q <= 5'h1; ld <= 1'b1; ld_cnt <= LONG_CY >> 1;
        end
        S_ON: begin
          st_q <= S_OFF; led <= 1'b0; ld <= 1'b1; ld_cnt <= LONG_CY >> 1;
        end
        S_OFF: begin
          if (n_q != blinks) begin
            n_q <= n_q + 5'h1; st_q <= S_ON; led <= 1'b1;
            ld <= 1'b1; ld_cnt <= LONG_CY >> 1;
          end else if (dig_q != 2'h0) begin
            dig_q <= dig_q - 2'h1; st_q <= S_DGAP; ld <= 1'b1; ld_cnt <= DIGIT_CY;
          end else begin
            st_q <= S_RGAP; ld <= 1'b1; ld_cnt <= REPEAT_CY;
          end
        end
        S_RGAP: begin
          st_q <= S_PRE_ON; led <= 1'b1; n_q <= 5'h1; ld <= 1'b1; ld_cnt <= SHORT_CY;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // srf_blink
`default_nettype wire

//--- rtl/srf_map.vh
`ifndef SRF_MAP_VH
`define SRF_MAP_VH
`define SRF_CLK_MHZ        200
`define SRF_SUPPLY_LOSS_MS 20
`define SRF_SUPPLY_LOSS_CY (`SRF_SUPPLY_LOSS_MS * `SRF_CLK_MHZ * 1000)
`define SRF_POWER_OFF_MS   1000
`define SRF_POWER_OFF_CY   (`SRF_POWER_OFF_MS * `SRF_CLK_MHZ * 1000)
`define SRF_FB_MS          150
`define SRF_FB_CY          (`SRF_FB_MS * `SRF_CLK_MHZ * 1000)
`define SRF_LONG_MS        1000
`define SRF_LONG_CY        (`SRF_LONG_MS * `SRF_CLK_MHZ * 1000)
`define SRF_SHORT_MS       200
`define SRF_SHORT_CY       (`SRF_SHORT_MS * `SRF_CLK_MHZ * 1000)
`define SRF_DIGIT_GAP_MS   3000
`define SRF_DIGIT_GAP_CY   (`SRF_DIGIT_GAP_MS * `SRF_CLK_MHZ * 1000)
`define SRF_REPEAT_GAP_MS  5000
`define SRF_REPEAT_GAP_CY  (`SRF_REPEAT_GAP_MS * `SRF_CLK_MHZ * 1000)
`define SRF_INIT_MS        500
`define SRF_INIT_CY        (`SRF_INIT_MS * `SRF_CLK_MHZ * 1000)
`define SRF_PULSE_PERIOD_CY 200000
`define SRF_PULSE_LEN_CY   100
`define SRF_PREAMBLE_N     4'h3
`define SRF_ZERO_BLINKS    5'h10
`define SRF_FB_CODE        16'h0018
`define SRF_SUPPLY_CODE    16'h0082
`endif

//--- rtl/srf_timer.v
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Down counter: load, count, done level held at zero
module srf_timer (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        load,
  input  wire [31:0] count,
  output wire        done
);
  reg [31:0] cnt_q;
  // Count down to zero, reload on request
  always @(posedge sys_clk) begin
    if (sys_rst)
      cnt_q <= 32'h0;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != 32'h0)
      cnt_q <= cnt_q - 32'h1;
  end
  assign done = (cnt_q == 32'h0) && !load;
endmodule // srf_timer
`default_nettype wire

//--- rtl/srf_top.v
`include "srf_map.vh"
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Safety relay status and fault indication
module srf_top #(
  parameter [31:0] SUPPLY_LOSS_CY = `SRF_SUPPLY_LOSS_CY,
  parameter [31:0] POWER_OFF_CY   = `SRF_POWER_OFF_CY,
  parameter [31:0] FB_CY          = `SRF_FB_CY,
  parameter [31:0] INIT_CY        = `SRF_INIT_CY,
  parameter [31:0] SHORT_CY       = `SRF_SHORT_CY,
  parameter [31:0] LONG_CY        = `SRF_LONG_CY,
  parameter [31:0] DIGIT_CY       = `SRF_DIGIT_GAP_CY,
  parameter [31:0] REPEAT_CY      = `SRF_REPEAT_GAP_CY,
  parameter [31:0] PULSE_PERIOD   = `SRF_PULSE_PERIOD_CY,
  parameter [31:0] PULSE_LEN      = `SRF_PULSE_LEN_CY
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        supply_ok,
  input  wire        mode_valid,
  input  wire        start_done,
  input  wire        own_demand,
  input  wire        or_link_input,
  input  wire        and_link_input,
  input  wire        delay_expired,
  input  wire        instant_feedback_input,
  input  wire        delayed_feedback_input,
  input  wire        fault_req,
  input  wire [15:0] fault_code,
  input  wire [2:0]  fault_digits,
  output reg         instant_out,
  output reg         delayed_out,
  output reg         power_led,
  output wire        first_channel_led,
  output wire        second_channel_led,
  output wire        fault_active,
  output wire        cut_delay
);
  localparam [1:0] P_INIT = 2'h0, P_WAIT = 2'h1, P_RUN = 2'h2;
  reg  [1:0]  ph_q;
  reg  [31:0] init_q, loss_q, off_q, fbi_q, fbd_q, pul_q, blk_q;
  reg         blink_q, sup_err_q, fb_err_q, off_ok_q, inst_q, del_q;
  reg         inst_d, del_d;
  wire        demand, ext_fault, any_err, ind_led, run;
  wire [15:0] code;
  wire [2:0]  nd;

  // =====================================================
  // Safety demand combination
  assign demand = (own_demand && and_link_input) || or_link_input;
  assign any_err = sup_err_q || fb_err_q || fault_req;
  assign fault_active = any_err;
  assign cut_delay = any_err;
  assign run = (ph_q == P_RUN) && !any_err;

  // Next output values before test pulses
  always @* begin
    inst_d = run && demand;
    del_d  = run && demand && (del_q || delay_expired);
  end

  // =====================================================
  // Power-up phase: init, wait for mode/start, run
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_q <= P_INIT;
      init_q <= 32'h0;
    end else begin
      case (ph_q)
        P_INIT: begin
          init_q <= init_q + 32'h1;
          if (init_q >= INIT_CY)
            ph_q <= P_WAIT;
        end
        P_WAIT: if (mode_valid && start_done) ph_q <= P_RUN;
        P_RUN:  if (!mode_valid) ph_q <= P_WAIT;
        default: ph_q <= P_INIT;
      endcase
    end
  end

  // Power LED blink base and drive
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      blk_q <= 32'h0; blink_q <= 1'b0; power_led <= 1'b0;
    end else begin
      blk_q <= (blk_q >= (LONG_CY >> 1)) ? 32'h0 : blk_q + 32'h1;
      if (blk_q >= (LONG_CY >> 1)) blink_q <= !blink_q;
      power_led <= (ph_q == P_RUN) ? 1'b1 : blink_q;
    end
  end

  // =====================================================
  // Supply interruption and power-off qualification
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      loss_q <= 32'h0; off_q <= 32'h0; sup_err_q <= 1'b0; off_ok_q <= 1'b0;
    end else begin
      loss_q <= supply_ok ? 32'h0 : (loss_q == 32'hffffffff ? loss_q : loss_q + 32'h1);
      if (!supply_ok && loss_q >= SUPPLY_LOSS_CY)
        sup_err_q <= 1'b1;
      off_q <= supply_ok ? 32'h0 : (off_q == 32'hffffffff ? off_q : off_q + 32'h1);
      if (sup_err_q && !supply_ok && off_q >= POWER_OFF_CY)
        off_ok_q <= 1'b1;
      if (off_ok_q && supply_ok) begin
        sup_err_q <= 1'b0;
        off_ok_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // Feedback timeout after a falling output
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fbi_q <= 32'h0; fbd_q <= 32'h0; fb_err_q <= 1'b0;
    end else begin
      if (inst_q && !inst_d) fbi_q <= FB_CY;
      else if (instant_feedback_input) fbi_q <= 32'h0;
      else if (fbi_q != 32'h0) fbi_q <= fbi_q - 32'h1;
      if (del_q && !del_d) fbd_q <= FB_CY;
      else if (delayed_feedback_input) fbd_q <= 32'h0;
      else if (fbd_q != 32'h0) fbd_q <= fbd_q - 32'h1;
      if ((fbi_q == 32'h1 && !instant_feedback_input) ||
          (fbd_q == 32'h1 && !delayed_feedback_input))
        fb_err_q <= 1'b1;
    end
  end

  // =====================================================
  // Outputs with periodic test pulses
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      inst_q <= 1'b0; del_q <= 1'b0; pul_q <= 32'h0;
      instant_out <= 1'b0; delayed_out <= 1'b0;
    end else begin
      inst_q <= inst_d;
      del_q  <= del_d;
      pul_q  <= (pul_q >= PULSE_PERIOD) ? 32'h0 : pul_q + 32'h1;
      instant_out <= inst_d && !(pul_q < PULSE_LEN);
      delayed_out <= del_d && !(pul_q < PULSE_LEN);
    end
  end

  // Channel LEDs follow logical output state unless a code shows
  assign code = sup_err_q ? `SRF_SUPPLY_CODE : fb_err_q ? `SRF_FB_CODE : fault_code;
  assign nd   = (sup_err_q || fb_err_q) ? 3'h2 : fault_digits;
  assign first_channel_led  = any_err ? ind_led : inst_q;
  assign second_channel_led = any_err ? ind_led : del_q;

  srf_blink #(
    .SHORT_CY  (SHORT_CY),
    .LONG_CY   (LONG_CY),
    .DIGIT_CY  (DIGIT_CY),
    .REPEAT_CY (REPEAT_CY)
  ) u_blink (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .active  (any_err),
    .code    (code),
    .ndigits (nd),
    .led     (ind_led)
  );
endmodule // srf_top
`default_nettype wire
